// File: design/host_ctl.sv
// host-side pulse generator for power toggle and hardware reset pins
module host_ctl
	import pwr_ctl_pkg::*;
#(
	parameter int unsigned CYC_MS = pwr_ctl_pkg::CYC_PER_MS,
	parameter int unsigned ON_T = pwr_ctl_pkg::HOST_ON_MS,
	parameter int unsigned OFF_T = pwr_ctl_pkg::HOST_OFF_MS,
	parameter int unsigned RST_T = pwr_ctl_pkg::HOST_RESET_MS,
	parameter int unsigned ATTACH_T = pwr_ctl_pkg::ATTACH_MS
)
(
	input wire logic ref_clk_i,
	input wire logic reset_i,
	pwr_ctl_if.host pins,
	input wire logic power_on_req_i,
	input wire logic power_off_req_i,
	input wire logic reset_req_i,
	output logic busy_o,
	output logic attach_seen_o,
	output logic attach_timeout_o
);
	import pwr_ctl_pkg::*;

	// divider sized from the clock rate so the millisecond tick never wraps early
	localparam int DIV_W = (CYC_MS > 1) ? $clog2(CYC_MS) : 1;

	typedef enum logic [3:0] {
		H_IDLE = 4'b0001,
		H_TOG = 4'b0010,
		H_RST = 4'b0100,
		H_WAIT = 4'b1000
	} host_st_t;

	typedef struct packed {
		host_st_t st;
		logic [DIV_W-1:0] div;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] target;
		logic probe;
		logic seen;
		logic timeout;
	} hstate_t;

	hstate_t h_reg;
	hstate_t h_next;
	logic ms_tick;

	assign ms_tick = (h_reg.div == DIV_W'(CYC_MS - 1));

	// on pulse kept inside 0.5..1 s, off pulse inside 0.5..4 s, reset under 2 s
	always_comb
	begin
		h_next = h_reg;
		h_next.div = ms_tick ? '0 : h_reg.div + 1'b1;
		case (h_reg.st)
			H_IDLE:
			begin
				h_next.cnt = '0;
				if (power_on_req_i)
				begin
					h_next.st = H_TOG;
					h_next.target = CNT_W'(ON_T); // [RULE_02]
					h_next.probe = 1'b1;
					h_next.seen = 1'b0;
					h_next.timeout = 1'b0;
				end
				else if (power_off_req_i)
				begin
					h_next.st = H_TOG;
					h_next.target = CNT_W'(OFF_T); // [RULE_03]
					h_next.probe = 1'b0;
				end
				else if (reset_req_i)
				begin
					h_next.st = H_RST;
					h_next.target = CNT_W'(RST_T); // [RULE_07]
				end
			end
			H_TOG, H_RST:
			begin
				if (ms_tick)
				begin
					h_next.cnt = h_reg.cnt + 1'b1;
				end
				if (h_reg.cnt >= h_reg.target)
				begin
					h_next.cnt = '0;
					h_next.st = h_reg.probe ? H_WAIT : H_IDLE;
				end
			end
			H_WAIT:
			begin
				if (ms_tick)
				begin
					h_next.cnt = h_reg.cnt + 1'b1;
				end
				if (pins.usb_dp_pullup)
				begin
					h_next.seen = 1'b1;
				end
				// conclude only after the attach delay has fully passed
				if (h_reg.cnt > CNT_W'(2 * ATTACH_T))
				begin
					h_next.timeout = ~(h_reg.seen | pins.usb_dp_pullup); // [RULE_05]
					h_next.probe = 1'b0;
					h_next.st = H_IDLE;
				end
			end
			default:
			begin
				h_next.st = H_IDLE;
			end
		endcase
	end

	// single register for all state
	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			h_reg <= '0;
			h_reg.st <= H_IDLE;
		end
		else
		begin
			h_reg <= h_next;
		end
	end

	assign pins.power_toggle_n = ~(h_reg.st == H_TOG); // [RULE_01]
	assign pins.hw_reset_n = ~(h_reg.st == H_RST);
	assign busy_o = (h_reg.st != H_IDLE);
	assign attach_seen_o = h_reg.seen;
	assign attach_timeout_o = h_reg.timeout;
endmodule

// File: design/modem_ctl.sv
// modem-side power toggle, hardware reset and status led control
// What this block does; RULE_02, RULE_03 and RULE_05 are kept by host_ctl
// [RULE_01] each long toggle pulse flips power state
// [RULE_02] host power-on pulse between 0.5 and 1 s
// [RULE_03] host power-off pulse between 0.5 and 4 s
// [RULE_04] usb d+ pulled high 4 s after power-on
// [RULE_05] host waits past attach delay before probing
// [RULE_06] reset low over 50 ms resets hardware
// [RULE_07] reset low beyond 2 s powers off
// [RULE_08] after reset reboot and send boot report
// [RULE_09] power down disables external output rails
// [RULE_10] sleep puts output rails in low power
// [RULE_11] led outputs sink current when active
// [RULE_12] 3g registered: status blinks once, mode off
// [RULE_13] 3g data: status steady on, mode off
// [RULE_14] upgrade: status off, mode blinks fast
// [RULE_15] searching: status off, mode blinks twice
// [RULE_16] 2g registered: status off, mode blinks once
// [RULE_17] 2g data: status off, mode steady on
// [RULE_18] blink timings are parameters
// [RULE_19] synchronise pins, count low time first
module modem_ctl
	import pwr_ctl_pkg::*;
#(
	parameter int unsigned CYC_MS = pwr_ctl_pkg::CYC_PER_MS,
	parameter int unsigned ATTACH_T = pwr_ctl_pkg::ATTACH_MS,
	parameter int unsigned TOG_MIN_T = pwr_ctl_pkg::TOGGLE_MIN_MS,
	parameter int unsigned RST_MIN_T = pwr_ctl_pkg::RESET_MIN_MS,
	parameter int unsigned RST_MAX_T = pwr_ctl_pkg::RESET_MAX_MS,
	parameter int unsigned BOOT_T = pwr_ctl_pkg::BOOT_MS,
	parameter int unsigned PERIOD_T = pwr_ctl_pkg::BLINK_PERIOD_MS
)
(
	input wire logic ref_clk_i,
	input wire logic reset_i,
	pwr_ctl_if.device pins,
	input wire pwr_ctl_pkg::net_cond_t net_cond_i,
	input wire logic sleep_i,
	output logic powered_o,
	output logic aux_rail_low_en_o,
	output logic aux_rail_high_en_o,
	output logic card_rail_en_o,
	output logic aux_rail_lowpwr_o,
	output logic boot_done_report_o
);
	import pwr_ctl_pkg::*;

	// divider sized from the clock rate; a 16-bit one would wrap before 1 ms at 100 MHz
	localparam int DIV_W = (CYC_MS > 1) ? $clog2(CYC_MS) : 1;

	typedef enum logic [3:0] {
		ST_OFF = 4'b0001,
		ST_BOOT = 4'b0010,
		ST_RUN = 4'b0100,
		ST_RESET = 4'b1000
	} pwr_st_t;

	typedef struct packed {
		logic [1:0] tog_sync;
		logic [1:0] rst_sync;
		logic [DIV_W-1:0] div;
		logic [CNT_W-1:0] tog_cnt;
		logic [CNT_W-1:0] rst_cnt;
		logic [CNT_W-1:0] up_cnt;
		logic [CNT_W-1:0] blink_cnt;
		pwr_st_t st;
		logic tog_done;
		logic attached;
		logic report;
		logic state_led;
		logic kind_led;
	} state_t;

	state_t s_reg;
	state_t s_next;
	logic ms_tick;
	logic tog_low;
	logic rst_low;
	led_pat_t state_pat;
	led_pat_t kind_pat;
	logic once_lit;
	logic twice_lit;
	logic fast_lit;

	// saturating increment keeps long-held pins from wrapping the counters
	function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
		sat_inc = (&v) ? v : v + 1'b1;
	endfunction

	// pattern to lit level; active means sinking the cathode
	function automatic logic pat_lit(input led_pat_t p, input logic once_v,
		input logic twice_v);
		case (p)
			PAT_ON: pat_lit = 1'b1;
			PAT_ONCE: pat_lit = once_v;
			PAT_TWICE: pat_lit = twice_v;
			default: pat_lit = 1'b0;
		endcase
	endfunction

	assign ms_tick = (s_reg.div == DIV_W'(CYC_MS - 1));
	assign tog_low = ~s_reg.tog_sync[1]; // [RULE_19]
	assign rst_low = ~s_reg.rst_sync[1]; // [RULE_19]

	// blink phases derived from one cycle counter
	assign once_lit = (s_reg.blink_cnt < CNT_W'(BLINK_ON_MS)); // [RULE_18]
	assign twice_lit = once_lit
		| ((s_reg.blink_cnt >= CNT_W'(BLINK_ON_MS + BLINK_OFF_MS))
		& (s_reg.blink_cnt < CNT_W'(2 * BLINK_ON_MS + BLINK_OFF_MS))); // [RULE_18]
	assign fast_lit = ((s_reg.blink_cnt % CNT_W'(FAST_ON_MS + FAST_OFF_MS))
		< CNT_W'(FAST_ON_MS)); // [RULE_18]

	// led pattern table per network condition
	always_comb
	begin
		state_pat = PAT_OFF;
		kind_pat = PAT_OFF;
		case (net_cond_i)
			NET_REG_3G: state_pat = PAT_ONCE; // [RULE_12]
			NET_DATA_3G: state_pat = PAT_ON; // [RULE_13]
			NET_UPGRADE: kind_pat = PAT_ON; // fast blink applied below [RULE_14]
			NET_SEARCH: kind_pat = PAT_TWICE; // [RULE_15]
			NET_REG_2G: kind_pat = PAT_ONCE; // [RULE_16]
			NET_DATA_2G: kind_pat = PAT_ON; // [RULE_17]
			default:
			begin
				state_pat = PAT_OFF;
				kind_pat = PAT_OFF;
			end
		endcase
	end

	// whole next state in one place
	always_comb
	begin
		s_next = s_reg;
		s_next.tog_sync = {s_reg.tog_sync[0], pins.power_toggle_n}; // [RULE_19]
		s_next.rst_sync = {s_reg.rst_sync[0], pins.hw_reset_n}; // [RULE_19]
		s_next.div = ms_tick ? '0 : s_reg.div + 1'b1;
		s_next.report = 1'b0;
		if (ms_tick)
		begin
			s_next.blink_cnt = (s_reg.blink_cnt >= CNT_W'(PERIOD_T - 1)) ? '0
				: s_reg.blink_cnt + 1'b1;
		end
		// low-time counters run only while the pin is low
		if (!tog_low)
		begin
			s_next.tog_cnt = '0;
			s_next.tog_done = 1'b0;
		end
		else if (ms_tick)
		begin
			s_next.tog_cnt = sat_inc(s_reg.tog_cnt);
		end
		if (!rst_low)
		begin
			s_next.rst_cnt = '0;
		end
		else if (ms_tick)
		begin
			s_next.rst_cnt = sat_inc(s_reg.rst_cnt);
		end
		// act once per pulse when 0.5 s is reached; no wait for release
		if (tog_low && !s_reg.tog_done && s_reg.tog_cnt >= CNT_W'(TOG_MIN_T))
		begin
			s_next.tog_done = 1'b1; // [RULE_01]
			if (s_reg.st == ST_OFF)
			begin
				s_next.st = ST_BOOT; // [RULE_01]
				s_next.up_cnt = '0;
			end
			else
			begin
				s_next.st = ST_OFF; // [RULE_01]
				s_next.attached = 1'b0;
			end
		end
		else
		begin
			case (s_reg.st)
				ST_OFF:
				begin
					s_next.attached = 1'b0;
				end
				ST_BOOT, ST_RUN:
				begin
					if (ms_tick && !s_reg.attached)
					begin
						s_next.up_cnt = sat_inc(s_reg.up_cnt);
					end
					if (s_reg.up_cnt >= CNT_W'(ATTACH_T))
					begin
						s_next.attached = 1'b1; // [RULE_04]
					end
					if (s_reg.st == ST_BOOT && s_reg.up_cnt >= CNT_W'(BOOT_T))
					begin
						s_next.st = ST_RUN;
						s_next.report = 1'b1; // [RULE_08]
					end
					if (rst_low && s_reg.rst_cnt > CNT_W'(RST_MIN_T))
					begin
						s_next.st = ST_RESET; // [RULE_06]
						s_next.attached = 1'b0;
					end
				end
				ST_RESET:
				begin
					if (rst_low && s_reg.rst_cnt > CNT_W'(RST_MAX_T))
					begin
						s_next.st = ST_OFF; // [RULE_07]
					end
					else if (!rst_low)
					begin
						s_next.st = ST_BOOT; // [RULE_08]
						s_next.up_cnt = '0;
					end
				end
				default:
				begin
					s_next.st = ST_OFF;
				end
			endcase
		end
		s_next.state_led = (s_reg.st == ST_RUN) && pat_lit(state_pat, once_lit, twice_lit);
		s_next.kind_led = (s_reg.st == ST_RUN) && ((net_cond_i == NET_UPGRADE) ? fast_lit
			: pat_lit(kind_pat, once_lit, twice_lit)); // [RULE_14]
	end

	// single register for all state
	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			s_reg <= '0;
			s_reg.tog_sync <= 2'h3;
			s_reg.rst_sync <= 2'h3;
			s_reg.st <= ST_OFF;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	assign pins.usb_dp_pullup = s_reg.attached; // [RULE_04]
	assign pins.net_state_led_sink = s_reg.state_led; // [RULE_11]
	assign pins.net_kind_led_sink = s_reg.kind_led; // [RULE_11]
	assign powered_o = (s_reg.st != ST_OFF);
	// rails off in power down, low-power flag while asleep
	assign aux_rail_low_en_o = powered_o; // [RULE_09]
	assign aux_rail_high_en_o = powered_o; // [RULE_09]
	assign card_rail_en_o = powered_o; // [RULE_09]
	assign aux_rail_lowpwr_o = powered_o & sleep_i; // [RULE_10]
	assign boot_done_report_o = s_reg.report; // [RULE_08]
endmodule

// File: design/pwr_ctl_if.sv
// pins between the host terminal and the modem control logic
interface pwr_ctl_if;
	logic power_toggle_n;
	logic hw_reset_n;
	logic usb_dp_pullup;
	logic net_state_led_sink;
	logic net_kind_led_sink;
	modport device (
		input power_toggle_n,
		input hw_reset_n,
		output usb_dp_pullup,
		output net_state_led_sink,
		output net_kind_led_sink
	);
	modport host (
		output power_toggle_n,
		output hw_reset_n,
		input usb_dp_pullup,
		input net_state_led_sink,
		input net_kind_led_sink
	);
endinterface

// File: design/pwr_ctl_pkg.sv
// shared constants and types for the power, reset and status-led control pair
package pwr_ctl_pkg;
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned MS_PER_S = 1000;
	// pulse times in milliseconds
	localparam int unsigned TOGGLE_MIN_MS = 500;
	localparam int unsigned ON_MAX_MS = 1000;
	localparam int unsigned OFF_MAX_MS = 4000;
	localparam int unsigned ATTACH_MS = 4000;
	localparam int unsigned RESET_MIN_MS = 50;
	localparam int unsigned RESET_MAX_MS = 2000;
	localparam int unsigned BOOT_MS = 100;
	localparam int unsigned BLINK_ON_MS = 100;
	localparam int unsigned BLINK_OFF_MS = 100;
	localparam int unsigned BLINK_PERIOD_MS = 2000;
	localparam int unsigned FAST_ON_MS = 100;
	localparam int unsigned FAST_OFF_MS = 100;
	// a millisecond tick rate; all timing counts below are in ms ticks
	localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;
	localparam int CNT_W = 16;
	// host pulse targets; one length sits inside both the on and the off window
	localparam int unsigned HOST_ON_MS = (TOGGLE_MIN_MS + ON_MAX_MS) / 2;
	localparam int unsigned HOST_OFF_MS = (TOGGLE_MIN_MS + ON_MAX_MS) / 2;
	localparam int unsigned HOST_RESET_MS = 2 * RESET_MIN_MS;
	// network condition codes supplied by the modem firmware side
	typedef enum logic [2:0] {
		NET_IDLE = 3'h0,
		NET_REG_3G = 3'h1,
		NET_DATA_3G = 3'h2,
		NET_UPGRADE = 3'h3,
		NET_SEARCH = 3'h4,
		NET_REG_2G = 3'h5,
		NET_DATA_2G = 3'h6
	} net_cond_t;
	// led drive pattern
	typedef enum logic [1:0] {
		PAT_OFF = 2'h0,
		PAT_ON = 2'h1,
		PAT_ONCE = 2'h2,
		PAT_TWICE = 2'h3
	} led_pat_t;
endpackage

// File: verif/module_power_reset_led_control_test.sv
// self-checking bench for the host and modem control pair
module module_power_reset_led_control_test import pwr_ctl_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	// short ms tick keeps the blink periods affordable
	localparam int C = 4;
	localparam int AT = 40;
	localparam int TG = 5;
	localparam int RN = 2;
	localparam int RX = 20;
	localparam int BT = 4;
	localparam int P = BLINK_PERIOD_MS * C;
	localparam int B = BLINK_ON_MS * C;
	logic ref_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic sleep_i = 1'b0;
	logic pon = 1'b0;
	logic poff = 1'b0;
	logic rq = 1'b0;
	net_cond_t net_cond_i = NET_IDLE;
	logic busy, seen, tmo, pw, lp, bd, fpw, fbd;
	logic [2:0] rail;
	int err_count = 0;
	int n_tests = 0;
	int nb = 0;
	int nbf = 0;
	int n;
	pwr_ctl_if pins ();
	pwr_ctl_if flt ();
	always #5 ref_clk_i = ~ref_clk_i;
	modem_ctl #(.CYC_MS(C), .ATTACH_T(AT), .TOG_MIN_T(TG), .RST_MIN_T(RN), .RST_MAX_T(RX),
		.BOOT_T(BT)) u_modem_ctl (.ref_clk_i, .reset_i, .pins(pins.device), .net_cond_i,
		.sleep_i, .powered_o(pw), .aux_rail_low_en_o(rail[0]), .aux_rail_high_en_o(rail[1]),
		.card_rail_en_o(rail[2]), .aux_rail_lowpwr_o(lp), .boot_done_report_o(bd));
	// second modem end faces the bench, which breaks the host timing on purpose
	modem_ctl #(.CYC_MS(C), .ATTACH_T(AT), .TOG_MIN_T(TG), .RST_MIN_T(RN), .RST_MAX_T(RX),
		.BOOT_T(BT)) u_modem_ctl_flt (.ref_clk_i, .reset_i, .pins(flt.device), .net_cond_i,
		.sleep_i, .powered_o(fpw), .aux_rail_low_en_o(), .aux_rail_high_en_o(),
		.card_rail_en_o(), .aux_rail_lowpwr_o(), .boot_done_report_o(fbd));
	host_ctl #(.CYC_MS(C), .ON_T(8), .OFF_T(8), .RST_T(8), .ATTACH_T(AT)) u_host_ctl (
		.ref_clk_i, .reset_i, .pins(pins.host), .power_on_req_i(pon), .power_off_req_i(poff),
		.reset_req_i(rq), .busy_o(busy), .attach_seen_o(seen), .attach_timeout_o(tmo));
	pwr_ctl_sva #(.CYC_MS(C), .ATT(AT), .TOG(TG), .BOOT(BT), .RMIN(RN)) u_pwr_ctl_sva (
		.ref_clk_i, .reset_i, .power_toggle_n(pins.power_toggle_n),
		.hw_reset_n(pins.hw_reset_n), .usb_dp_pullup(pins.usb_dp_pullup),
		.net_state_led_sink(pins.net_state_led_sink),
		.net_kind_led_sink(pins.net_kind_led_sink));
	// count boot-complete pulses of both modem ends
	always @(posedge ref_clk_i)
	begin
		nb += (bd === 1'b1);
		nbf += (fbd === 1'b1);
	end
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] v, input logic [31:0] e);
		n_tests++;
		if (v !== e)
		begin
			err_count++;
			$display("mismatch %s expected %0h seen %0h", s, e, v);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge ref_clk_i);
	endtask
	function automatic bit ok(input int w);
		case (w)
			0: return busy === 1'b0;
			1: return busy === 1'b1;
			2: return pw === 1'b1;
			default: return pins.usb_dp_pullup === 1'b1;
		endcase
	endfunction
	// bounded wait; n keeps the cycles spent, a hang ends the run
	task automatic wt(input int w);
		for (n = 0; n < 9000 && !ok(w); n++)
			cyc(1);
		if (!ok(w))
		begin
			err_count++;
			final_report();
		end
	endtask
	// requests stay up until the host end takes them
	task automatic hreq(input logic [2:0] r);
		{pon, poff, rq} = r;
		wt(1);
		{pon, poff, rq} = 3'h0;
	endtask
	task automatic fp(input bit r, input int ms);
		if (r)
			flt.hw_reset_n = 1'b0;
		else
			flt.power_toggle_n = 1'b0;
		cyc(ms * C);
		flt.hw_reset_n = 1'b1;
		flt.power_toggle_n = 1'b1;
		cyc(2 * C);
	endtask
	// lit cycles over one whole period do not depend on the blink phase
	task automatic led(input net_cond_t c, input int es, input int ek);
		int s;
		int k;
		s = 0;
		k = 0;
		net_cond_i = c;
		cyc(3);
		repeat (P)
		begin
			cyc(1);
			s += (pins.net_state_led_sink === 1'b1);
			k += (pins.net_kind_led_sink === 1'b1);
		end
		chk("state led", s, es);
		chk("kind led", k, ek);
	endtask
	initial
	begin
		flt.power_toggle_n = 1'b1;
		flt.hw_reset_n = 1'b1;
		cyc(8);
		reset_i = 1'b0;
		sleep_i = 1'b1;
		cyc(2);
		chk("rails off", {pw, rail, lp}, 0);
		sleep_i = 1'b0;
		hreq(3'h4);
		wt(2);
		chk("on delay", n >= (TG - 1) * C && n < 8 * C, 1);
		wt(3);
		chk("attach delay", n >= (AT - 1) * C - 4 && n <= AT * C + 4, 1);
		wt(0);
		chk("attach seen", {seen, tmo}, 2'h2);
		chk("boot reports", nb, 1);
		chk("rails on", rail, 3'h7);
		sleep_i = 1'b1;
		cyc(1);
		chk("low power", lp, 1);
		sleep_i = 1'b0;
		led(NET_REG_3G, B, 0);
		led(NET_DATA_3G, P, 0);
		led(NET_UPGRADE, 0, P * FAST_ON_MS / (FAST_ON_MS + FAST_OFF_MS));
		led(NET_SEARCH, 0, 2 * B);
		led(NET_REG_2G, 0, B);
		led(NET_DATA_2G, 0, P);
		hreq(3'h1);
		wt(0);
		wt(3);
		chk("reset keeps power", pw, 1);
		chk("boot reports", nb, 2);
		net_cond_i = NET_DATA_3G;
		hreq(3'h2);
		wt(0);
		chk("power off", {pw, rail, pins.usb_dp_pullup}, 0);
		chk("leds off", {pins.net_state_led_sink, pins.net_kind_led_sink}, 0);
		fp(0, TG - 2);
		chk("short toggle", fpw, 0);
		fp(1, RX + 5);
		chk("reset while off", nbf + fpw, 0);
		fp(0, 3 * TG);
		chk("long toggle", fpw, 1);
		chk("first boot", nbf, 1);
		fp(1, RN + 3);
		cyc((BT + 1) * C);
		chk("reset reboot", nbf + fpw, 3);
		fp(1, RX + 5);
		chk("long reset", fpw, 0);
		final_report();
	end
endmodule

// File: verif/pwr_ctl_sva.sv
// concurrent checks on the pins between the host and modem control ends
module pwr_ctl_sva #(
	parameter int unsigned CYC_MS = 4,
	parameter int unsigned ATT = 40,
	parameter int unsigned TOG = 5,
	parameter int unsigned BOOT = 4,
	parameter int unsigned RMIN = 2
)
(
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic power_toggle_n,
	input wire logic hw_reset_n,
	input wire logic usb_dp_pullup,
	input wire logic net_state_led_sink,
	input wire logic net_kind_led_sink
);
	timeunit 1ns;
	timeprecision 1ps;
	int unsigned fall_reg;
	int unsigned rhi_reg;
	int unsigned rlo_reg;
	logic tq_reg;
	logic lit;
	assign lit = net_state_led_sink || net_kind_led_sink;
	// cycles since the toggle pin fell, length of the current reset low, time since release
	always_ff @(posedge ref_clk_i)
	begin
		tq_reg <= power_toggle_n;
		fall_reg <= (tq_reg && !power_toggle_n) ? 0 : fall_reg + (fall_reg < 99999);
		rlo_reg <= hw_reset_n ? 0 : rlo_reg + (rlo_reg < 99999);
		rhi_reg <= hw_reset_n ? rhi_reg + (rhi_reg < 99999) : 0;
	end
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	rst_dark_a: assert property ($past(reset_i) |-> !usb_dp_pullup && !lit)
		else $error("pins not dark after reset");
	attach_wait_a: assert property ($rose(usb_dp_pullup)
		|-> fall_reg >= (TOG + ATT - 2) * CYC_MS)
		else $error("attach came too early");
	// a led may first light only after boot time from a toggle fall and a reset release;
	// a lit led during the power-off pulse is legal, so only the rise is judged
	boot_first_a: assert property ($rose(lit)
		|-> fall_reg >= (TOG + BOOT - 2) * CYC_MS && rhi_reg >= BOOT * CYC_MS)
		else $error("led lit before boot ended");
	rst_hold_a: assert property (rlo_reg >= (RMIN + 2) * CYC_MS + 6
		|-> !usb_dp_pullup && !lit)
		else $error("held reset did not darken pins");
	lamp_excl_a: assert property (!(net_state_led_sink && net_kind_led_sink))
		else $error("both leds lit");
	drop_cause_a: assert property ($fell(usb_dp_pullup)
		|-> !power_toggle_n || !hw_reset_n || $past(reset_i))
		else $error("attach dropped without cause");
	hold_up_a: assert property (usb_dp_pullup && power_toggle_n
		&& $past(power_toggle_n, 4) && hw_reset_n && $past(hw_reset_n, 4) |=> usb_dp_pullup)
		else $error("attach fell while pins idle");
	rise_clean_a: assert property ($rose(usb_dp_pullup)
		|-> hw_reset_n && power_toggle_n)
		else $error("attach rose while a pin low");
	cover property ($rose(usb_dp_pullup));
	cover property ($rose(net_state_led_sink));
	cover property ($rose(net_kind_led_sink));
	cover property (rlo_reg == (RMIN + 3) * CYC_MS);
endmodule
